// [dv/smwt_host_model.sv]
// host microcontroller model: mode selects and serial threshold load.
// assumes the bench calls its tasks; lines idle low like the pull-downs.
`timescale 1ns/100ps
`default_nettype none
module smwt_host_model (
   // clock
   input wire logic clk,
   // selects and serial lines
   output var logic pressure_mode_select,
   output var logic temperature_mode_select,
   output var logic serial_clk,
   output var logic serial_data
);
   initial begin
      pressure_mode_select = 1'b0;
      temperature_mode_select = 1'b0;
      serial_clk = 1'b0;
      serial_data = 1'b0;
   end
   task automatic set_mode(input logic [1:0] code);
      @(posedge clk);
      #1 {temperature_mode_select, pressure_mode_select} = code;
   endtask
   // low n bits of v, msb first; only called outside measurement modes
   task automatic send_bits(input logic [7:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk);
         #1 serial_data = v[i];
         @(posedge clk);
         #1 serial_clk = 1'b1;
         @(posedge clk);
         #1 serial_clk = 1'b0;
      end
      @(posedge clk);
      #1 serial_data = 1'b0;
   endtask
endmodule
`default_nettype wire

// [dv/smwt_top_properties.sv]
// port-level checks for the mode decoder and wake timer.
// assumes binding into smwt_top; one clock domain, reset active low.
`timescale 1ns/100ps
`default_nettype none
module smwt_top_properties #(
   parameter int WAKE_STAGES = smwt_pkg::WAKE_STAGES,
   parameter int RESET_EXTRA_STAGES = smwt_pkg::RESET_EXTRA_STAGES
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // block inputs
   input wire logic pressure_mode_select,
   input wire logic temperature_mode_select,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic cmp_above,
   // block outputs
   input wire logic pressure_path_en,
   input wire logic pressure_mux_closed,
   input wire logic temp_path_en,
   input wire logic temp_mux_closed,
   input wire logic comparator_en,
   input wire logic [smwt_pkg::THR_W-1:0] threshold_register,
   input wire logic [1:0] active_mode,
   input wire logic out_pin,
   input wire logic host_reset_n
);
   localparam int PULSE_LEN = smwt_pkg::PULSE_TICKS * smwt_pkg::OSC_TICK_CYCLES;
   logic [15:0] low_cnt_reg;
   logic [1:0] sel;
   assign sel = {temperature_mode_select, pressure_mode_select};
   // length of the host reset pulse in progress
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt_reg <= 16'h0000;
      end else begin
         low_cnt_reg <= host_reset_n ? 16'h0000 : low_cnt_reg + 16'h0001;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   mode_decode_a: assert property (
      (!pressure_path_en && !temp_path_en) |=> active_mode == $past(sel))
      else $error("mode does not follow selects");
   press_paths_a: assert property (
      pressure_mux_closed |-> pressure_path_en && !temp_path_en && !temp_mux_closed
      && !comparator_en && active_mode == smwt_pkg::MODE_PRESSURE)
      else $error("pressure mode paths wrong");
   temp_paths_a: assert property (
      temp_mux_closed |-> temp_path_en && !pressure_path_en && !pressure_mux_closed
      && !comparator_en && active_mode == smwt_pkg::MODE_TEMPERATURE)
      else $error("temperature mode paths wrong");
   press_order_a: assert property (
      $fell(pressure_mux_closed) |-> pressure_path_en [*2] ##1
      (!pressure_path_en || pressure_mux_closed))
      else $error("pressure power dropped out of order");
   temp_order_a: assert property (
      $fell(temp_mux_closed) |-> temp_path_en [*2] ##1
      (!temp_path_en || temp_mux_closed))
      else $error("temperature power dropped out of order");
   comp_read_a: assert property (
      comparator_en |-> active_mode == smwt_pkg::MODE_READ && !pressure_path_en
      && !temp_path_en) else $error("comparator powered outside read");
   out_cmp_a: assert property (
      sel != smwt_pkg::MODE_STANDBY |=> out_pin == $past(cmp_above))
      else $error("output pin does not show comparator");
   rst_width_a: assert property (
      $rose(host_reset_n) |-> low_cnt_reg == 16'(PULSE_LEN))
      else $error("host reset pulse width wrong");
   wake_rst_a: assert property (
      !host_reset_n && !$past(host_reset_n) && $past(sel) == smwt_pkg::MODE_STANDBY
      |-> !out_pin) else $error("no wake pulse during host reset");
   thr_hold_a: assert property (
      (active_mode == smwt_pkg::MODE_PRESSURE || active_mode == smwt_pkg::MODE_TEMPERATURE)
      |=> $stable(threshold_register)) else $error("threshold changed while measuring");
   cover property ($rose(pressure_mux_closed));
   cover property ($fell(host_reset_n));
   cover property ($changed(threshold_register));
   cover property ($rose(serial_clk) && serial_data);
endmodule
bind smwt_top smwt_top_properties #(
   .WAKE_STAGES(WAKE_STAGES),
   .RESET_EXTRA_STAGES(RESET_EXTRA_STAGES)
) u_props (
   .clk(clk), .arst_n(arst_n), .pressure_mode_select(pressure_mode_select),
   .temperature_mode_select(temperature_mode_select), .serial_clk(serial_clk),
   .serial_data(serial_data), .cmp_above(cmp_above), .pressure_path_en(pressure_path_en),
   .pressure_mux_closed(pressure_mux_closed), .temp_path_en(temp_path_en),
   .temp_mux_closed(temp_mux_closed), .comparator_en(comparator_en),
   .threshold_register(threshold_register), .active_mode(active_mode),
   .out_pin(out_pin), .host_reset_n(host_reset_n)
);
`default_nettype wire

// [dv/smwt_top_test.sv]
// self-checking bench for the mode decoder and wake timer.
// assumes shortened dividers so a host reset pulse falls inside the run.
`timescale 1ns/100ps
`default_nettype none
module smwt_top_test;
   localparam int PULSE = smwt_pkg::PULSE_TICKS * smwt_pkg::OSC_TICK_CYCLES;
   logic clk, arst_n, cmp_above;
   logic p_sel, t_sel, s_clk, s_dat;
   logic p_en, p_mux, t_en, t_mux, c_en, out_pin, host_reset_n;
   logic [7:0] thr;
   logic [1:0] mode;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;
   smwt_host_model host (.clk(clk), .pressure_mode_select(p_sel),
      .temperature_mode_select(t_sel), .serial_clk(s_clk), .serial_data(s_dat));
   smwt_top #(.WAKE_STAGES(2), .RESET_EXTRA_STAGES(2)) DUT (.clk(clk), .arst_n(arst_n),
      .pressure_mode_select(p_sel), .temperature_mode_select(t_sel), .serial_clk(s_clk),
      .serial_data(s_dat), .cmp_above(cmp_above), .pressure_path_en(p_en),
      .pressure_mux_closed(p_mux), .temp_path_en(t_en), .temp_mux_closed(t_mux),
      .comparator_en(c_en), .threshold_register(thr), .active_mode(mode),
      .out_pin(out_pin), .host_reset_n(host_reset_n));
   task automatic step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // counts cycles until the watched pin reaches lvl, bounded by lim
   task automatic wait_for(input bit rst, input logic lvl, input int lim, output int k);
      k = 0;
      while ((rst ? host_reset_n : out_pin) !== lvl && k < lim) begin
         step(1);
         k++;
      end
      if (k >= lim) begin
         num_errors++;
         $display("wrong value at %0t: wait limit reached", $time);
      end
   endtask
   task automatic t_modes;
      logic [4:0] tab [4] = '{5'h00, 5'h18, 5'h06, 5'h01};
      for (int m = 1; m < 4; m++) begin
         host.set_mode(2'(m));
         step(3);
         chk(16'(mode), 16'(m), "mode");
         chk(16'({p_en, p_mux, t_en, t_mux, c_en}), 16'(tab[m]), "paths");
         host.set_mode(smwt_pkg::MODE_STANDBY);
         for (int k = 0; k < 4 && (p_mux | t_mux) !== 1'b0; k++) step(1);
         if (m < 3) begin
            chk(16'(p_en | t_en), 16'h0001, "power at mux open");
            step(1);
            chk(16'(p_en | t_en), 16'h0001, "power one cycle on");
            step(1);
            chk(16'(p_en | t_en), 16'h0000, "power off");
         end
         step(3);
         chk(16'({p_en, p_mux, t_en, t_mux, c_en}), 16'h0000, "standby paths");
      end
      $display("test modes done");
   endtask
   task automatic t_cmp;
      host.set_mode(smwt_pkg::MODE_READ);
      for (int b = 0; b < 2; b++) begin
         cmp_above = b[0];
         step(3);
         chk(16'(out_pin), 16'(b), "out follows comparator");
      end
      $display("test comparator done");
   endtask
   task automatic t_thr;
      host.send_bits(8'hA5, 8);
      step(2);
      chk(16'(thr), 16'h00A5, "byte in read mode");
      host.set_mode(smwt_pkg::MODE_STANDBY);
      host.send_bits(8'h3C, 8);
      step(2);
      chk(16'(thr), 16'h003C, "byte in standby");
      host.send_bits(8'h1F, 5);
      host.set_mode(smwt_pkg::MODE_PRESSURE);
      step(3);
      chk(16'(thr), 16'h003C, "partial byte");
      host.set_mode(smwt_pkg::MODE_STANDBY);
      step(6);
      host.send_bits(8'h96, 8);
      step(2);
      chk(16'(thr), 16'h0096, "count cleared by measuring");
      $display("test threshold done");
   endtask
   task automatic t_pulses;
      wait_for(0, 1'b1, 20000, n);
      wait_for(0, 1'b0, 20000, n);
      wait_for(0, 1'b1, 10000, n);
      chk(16'(n), 16'(PULSE), "wake width");
      wait_for(1, 1'b0, 60000, n);
      // out_pin trails the divider by one register stage
      step(1);
      chk(16'(out_pin), 16'h0000, "wake with host reset");
      wait_for(1, 1'b1, 10000, n);
      chk(16'(n + 1), 16'(PULSE), "host reset width");
      $display("test pulses done");
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 75000) begin
         num_errors++;
         $display("wrong value at %0t: run did not finish", $time);
         end_sim();
      end
   end
   initial begin
      arst_n = 1'b0;
      cmp_above = 1'b0;
      repeat (10) @(posedge clk);
      #1 arst_n = 1'b1;
      chk(16'({host_reset_n, out_pin, thr}), 16'h0300, "after reset");
      t_modes();
      t_cmp();
      t_thr();
      t_pulses();
      end_sim();
   end
endmodule
`default_nettype wire

// [verilog/smwt_divider.sv]
// oscillator tick and divider chain for the wake and host reset pulses.
// assumes clk at the package rate; stage counts may be cut for simulation.

`timescale 1ns/100ps
`default_nettype none

module smwt_divider #(
   parameter int WAKE_STAGES = smwt_pkg::WAKE_STAGES,
   parameter int RESET_EXTRA_STAGES = smwt_pkg::RESET_EXTRA_STAGES
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // pulses, low while active
   output logic wake_pulse_n,
   output logic reset_pulse_n
);

   localparam int TOTAL = WAKE_STAGES + RESET_EXTRA_STAGES;
   localparam logic [smwt_pkg::OSC_CNT_W-1:0] OSC_LAST =
      smwt_pkg::OSC_CNT_W'(smwt_pkg::OSC_TICK_CYCLES - 1);
   localparam logic [smwt_pkg::OSC_CNT_W-1:0] OSC_ZERO = 12'h000;
   localparam logic [TOTAL-1:0] CHAIN_RESET = TOTAL'(smwt_pkg::PULSE_TICKS);
   localparam logic [TOTAL-1:0] CHAIN_ONE = TOTAL'(1);
   localparam logic [WAKE_STAGES-1:0] WAKE_LIMIT = WAKE_STAGES'(smwt_pkg::PULSE_TICKS);
   localparam logic [TOTAL-1:0] RESET_LIMIT = TOTAL'(smwt_pkg::PULSE_TICKS);

   typedef struct packed {
      logic [smwt_pkg::OSC_CNT_W-1:0] osc_cnt;
      logic [TOTAL-1:0] chain;
      logic wake_n;
      logic reset_n;
   } smwt_div_state_t;

   smwt_div_state_t div_reg;
   smwt_div_state_t div_next;

   // ---------------------------------------------------------------
   // oscillator tick and chain
   // ---------------------------------------------------------------
   always_comb begin
      div_next = div_reg;
      if (div_reg.osc_cnt == OSC_LAST) begin
         div_next.osc_cnt = OSC_ZERO;
         div_next.chain = div_reg.chain + CHAIN_ONE;
      end else begin
         div_next.osc_cnt = div_reg.osc_cnt + 12'h001;
      end
      // low for the first two ticks after each overflow
      div_next.wake_n = !(div_next.chain[WAKE_STAGES-1:0] < WAKE_LIMIT);
      div_next.reset_n = !(div_next.chain < RESET_LIMIT);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_reg.osc_cnt <= OSC_ZERO;
         div_reg.chain <= CHAIN_RESET;
         div_reg.wake_n <= 1'b1;
         div_reg.reset_n <= 1'b1;
      end else begin
         div_reg <= div_next;
      end
   end

   assign wake_pulse_n = div_reg.wake_n;
   assign reset_pulse_n = div_reg.reset_n;

endmodule

`default_nettype wire

// [verilog/smwt_pkg.sv]
// constants, mode codes, state encodings and state record for the sensor
// mode decoder and wake timer.
// assumes a single 20 MHz system clock that also stands in for the
// low-frequency oscillator, which is modelled as a tick derived from it.

package smwt_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_FREQ_HZ = 20_000_000;
   localparam int CLK_PERIOD_NS = 50;
   localparam int OSC_FREQ_HZ = 5400;
   localparam int OSC_TICK_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;
   localparam int OSC_CNT_W = 12;
   localparam int WAKE_STAGES = 14;
   localparam int RESET_EXTRA_STAGES = 10;
   localparam int PULSE_TICKS = 2;
   localparam int MUX_LEAD_NS = 100;
   localparam int MUX_LEAD_RAW = (MUX_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MUX_LEAD_CYCLES = (MUX_LEAD_RAW < 1) ? 1 : MUX_LEAD_RAW;
   localparam int HOLD_W = 2;
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(MUX_LEAD_CYCLES - 1);
   localparam logic [HOLD_W-1:0] HOLD_ZERO = 2'h0;

   // ---------------------------------------------------------------
   // mode select codes {temperature_mode_select, pressure_mode_select}
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_STANDBY = 2'h0;
   localparam logic [1:0] MODE_PRESSURE = 2'h1;
   localparam logic [1:0] MODE_TEMPERATURE = 2'h2;
   localparam logic [1:0] MODE_READ = 2'h3;

   // ---------------------------------------------------------------
   // serial threshold load
   // ---------------------------------------------------------------
   localparam int THR_W = 8;
   localparam int BIT_CNT_W = 3;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 3'h0;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 3'h1;
   localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = 3'h7;
   localparam logic [THR_W-1:0] THRESHOLD_RESET = 8'h00;

   // ---------------------------------------------------------------
   // mode state machine
   // ---------------------------------------------------------------
   typedef enum logic [5:0] {
      SMWT_ST_STANDBY = 6'h01,
      SMWT_ST_PRESS = 6'h02,
      SMWT_ST_PRESS_HOLD = 6'h04,
      SMWT_ST_TEMP = 6'h08,
      SMWT_ST_TEMP_HOLD = 6'h10,
      SMWT_ST_READ = 6'h20
   } smwt_state_t;

   typedef struct packed {
      smwt_state_t state;
      logic [HOLD_W-1:0] hold_cnt;
      logic sclk_prev;
      logic [THR_W-1:0] shift;
      logic [BIT_CNT_W-1:0] bit_cnt;
      logic [THR_W-1:0] threshold;
      logic press_en;
      logic press_mux;
      logic temp_en;
      logic temp_mux;
      logic cmp_en;
      logic out_pin;
      logic [1:0] mode;
   } smwt_top_state_t;

endpackage

// [verilog/smwt_top.sv]
// mode decode, power sequencing, serial threshold load and output pin
// selection for the sensor interface.
// assumes all inputs are synchronous to clk; the analog comparator result
// arrives as cmp_above and the power and mux controls go to analog cells.

`timescale 1ns/100ps
`default_nettype none

module smwt_top #(
   parameter int WAKE_STAGES = smwt_pkg::WAKE_STAGES,
   parameter int RESET_EXTRA_STAGES = smwt_pkg::RESET_EXTRA_STAGES
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // mode selects from the host
   input wire logic pressure_mode_select,
   input wire logic temperature_mode_select,
   // serial threshold input
   input wire logic serial_clk,
   input wire logic serial_data,
   // analog comparator result, high when sample is above threshold
   input wire logic cmp_above,
   // measurement path controls
   output logic pressure_path_en,
   output logic pressure_mux_closed,
   output logic temp_path_en,
   output logic temp_mux_closed,
   output logic comparator_en,
   output logic [smwt_pkg::THR_W-1:0] threshold_register,
   // status
   output logic [1:0] active_mode,
   // host pins
   output logic out_pin,
   output logic host_reset_n
);

   smwt_pkg::smwt_top_state_t top_reg;
   smwt_pkg::smwt_top_state_t top_next;

   logic [1:0] mode_sel;
   logic measuring;
   logic sclk_rise;
   logic sclk_fall;
   logic wake_pulse_n;
   logic reset_pulse_n;

   // ---------------------------------------------------------------
   // divider chain
   // ---------------------------------------------------------------
   smwt_divider #(
      .WAKE_STAGES(WAKE_STAGES),
      .RESET_EXTRA_STAGES(RESET_EXTRA_STAGES)
   ) u_divider (
      .clk(clk),
      .arst_n(arst_n),
      .wake_pulse_n(wake_pulse_n),
      .reset_pulse_n(reset_pulse_n)
   );

   // ---------------------------------------------------------------
   // select decode
   // ---------------------------------------------------------------
   // pad pull-downs resolve an open select to low
   assign mode_sel = {temperature_mode_select, pressure_mode_select};
   assign measuring = (mode_sel == smwt_pkg::MODE_PRESSURE) ||
                      (mode_sel == smwt_pkg::MODE_TEMPERATURE);
   assign sclk_rise = serial_clk && !top_reg.sclk_prev;
   assign sclk_fall = !serial_clk && top_reg.sclk_prev;

   // target state for a given select code
   function automatic smwt_pkg::smwt_state_t mode_target(input logic [1:0] sel);
      smwt_pkg::smwt_state_t t;
      t = smwt_pkg::SMWT_ST_STANDBY;
      case (sel)
         smwt_pkg::MODE_PRESSURE: begin
            t = smwt_pkg::SMWT_ST_PRESS;
         end
         smwt_pkg::MODE_TEMPERATURE: begin
            t = smwt_pkg::SMWT_ST_TEMP;
         end
         smwt_pkg::MODE_READ: begin
            t = smwt_pkg::SMWT_ST_READ;
         end
         default: begin
            t = smwt_pkg::SMWT_ST_STANDBY;
         end
      endcase
      return t;
   endfunction

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      top_next = top_reg;
      top_next.mode = mode_sel;

      // mode state machine
      case (top_reg.state)
         smwt_pkg::SMWT_ST_STANDBY,
         smwt_pkg::SMWT_ST_READ: begin
            top_next.state = mode_target(mode_sel);
         end
         smwt_pkg::SMWT_ST_PRESS: begin
            if (mode_sel != smwt_pkg::MODE_PRESSURE) begin
               // mux opens now, power stays until the hold ends
               top_next.state = smwt_pkg::SMWT_ST_PRESS_HOLD;
               top_next.hold_cnt = smwt_pkg::HOLD_LOAD;
            end
         end
         smwt_pkg::SMWT_ST_TEMP: begin
            if (mode_sel != smwt_pkg::MODE_TEMPERATURE) begin
               top_next.state = smwt_pkg::SMWT_ST_TEMP_HOLD;
               top_next.hold_cnt = smwt_pkg::HOLD_LOAD;
            end
         end
         smwt_pkg::SMWT_ST_PRESS_HOLD,
         smwt_pkg::SMWT_ST_TEMP_HOLD: begin
            if (top_reg.hold_cnt == smwt_pkg::HOLD_ZERO) begin
               top_next.state = mode_target(mode_sel);
            end else begin
               top_next.hold_cnt = top_reg.hold_cnt - 2'h1;
            end
         end
         default: begin
            top_next.state = smwt_pkg::SMWT_ST_STANDBY;
            top_next.hold_cnt = smwt_pkg::HOLD_ZERO;
         end
      endcase

      // power and mux controls follow the state
      top_next.press_en = (top_next.state == smwt_pkg::SMWT_ST_PRESS) ||
                          (top_next.state == smwt_pkg::SMWT_ST_PRESS_HOLD);
      top_next.press_mux = (top_next.state == smwt_pkg::SMWT_ST_PRESS);
      top_next.temp_en = (top_next.state == smwt_pkg::SMWT_ST_TEMP) ||
                         (top_next.state == smwt_pkg::SMWT_ST_TEMP_HOLD);
      top_next.temp_mux = (top_next.state == smwt_pkg::SMWT_ST_TEMP);
      top_next.cmp_en = (top_next.state == smwt_pkg::SMWT_ST_READ);

      // serial shift in every mode; bit count and threshold latch held off in pressure and temperature modes
      top_next.sclk_prev = serial_clk;
      if (sclk_rise) begin
         top_next.shift = {top_reg.shift[smwt_pkg::THR_W-2:0], serial_data};
      end
      if (measuring) begin
         top_next.bit_cnt = smwt_pkg::BIT_CNT_ZERO;
      end else if (sclk_fall) begin
         if (top_reg.bit_cnt == smwt_pkg::BIT_CNT_LAST) begin
            top_next.threshold = top_reg.shift;
            top_next.bit_cnt = smwt_pkg::BIT_CNT_ZERO;
         end else begin
            top_next.bit_cnt = top_reg.bit_cnt + smwt_pkg::BIT_CNT_ONE;
         end
      end

      // output pin: wake pulses in standby, comparator otherwise
      if (mode_sel == smwt_pkg::MODE_STANDBY) begin
         top_next.out_pin = wake_pulse_n;
      end else begin
         top_next.out_pin = cmp_above;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         top_reg.state <= smwt_pkg::SMWT_ST_STANDBY;
         top_reg.hold_cnt <= smwt_pkg::HOLD_ZERO;
         top_reg.sclk_prev <= 1'b0;
         top_reg.shift <= smwt_pkg::THRESHOLD_RESET;
         top_reg.bit_cnt <= smwt_pkg::BIT_CNT_ZERO;
         top_reg.threshold <= smwt_pkg::THRESHOLD_RESET;
         top_reg.press_en <= 1'b0;
         top_reg.press_mux <= 1'b0;
         top_reg.temp_en <= 1'b0;
         top_reg.temp_mux <= 1'b0;
         top_reg.cmp_en <= 1'b0;
         top_reg.out_pin <= 1'b1;
         top_reg.mode <= smwt_pkg::MODE_STANDBY;
      end else begin
         top_reg <= top_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign pressure_path_en = top_reg.press_en;
   assign pressure_mux_closed = top_reg.press_mux;
   assign temp_path_en = top_reg.temp_en;
   assign temp_mux_closed = top_reg.temp_mux;
   assign comparator_en = top_reg.cmp_en;
   assign threshold_register = top_reg.threshold;
   assign active_mode = top_reg.mode;
   assign out_pin = top_reg.out_pin;
   assign host_reset_n = reset_pulse_n;

endmodule

`default_nettype wire
